// ===== core/tsdp_port.sv
`timescale 1ns/1ps
//
// Contract
// (RULE_01) format 3 selects asynchronous transparent mode
// (RULE_02) async bypasses packet, fifo, whitening, fec
// (RULE_03) async only with fsk, gfsk, ook
// (RULE_04) controller starts and stops via strobes
// (RULE_05) transmit level sampled at eight times rate
// (RULE_06) source bit error under one eighth
// (RULE_07) format 1 selects synchronous clock/data mode
// (RULE_08) sync mode needs nrz, line code off
// (RULE_09) device drives serial clock, controller follows
// (RULE_10) tx data on pin zero, input during tx
// (RULE_11) rx data on pin selected for output
// (RULE_12) no sync word: controller handles framing
// (RULE_13) sync word on: device frames, payload only
// (RULE_14) code 0x2d shows pin zero input, low
// (RULE_15) serial pins resynchronised before use
//
module tsdp_port (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // general pins, three signals each
   input  wire logic [2:0]  gpin_in,
   output logic      [2:0]  gpin_out,
   output logic      [2:0]  gpin_oe,
   // modem side
   input  wire logic        demod_bit,
   output logic             mod_bit,
   output logic             mod_bit_valid,
   output logic             tx_active,
   output logic             rx_active,
   output logic             packet_bypass,
   output logic             frame_insert
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]           fmt;      // packet_format_select
      logic                 line;     // line_code_enable
      logic [2:0]           syncm;    // sync_word_mode
      logic [2:0]           modf;     // modulation format
      logic [5:0]           pin0_sel; // pin_zero_function_select
      logic [5:0]           pin1_sel; // pin_one_function_select
      logic [5:0]           pin2_sel; // pin_two_function_select
      logic [15:0]          rate;     // cycles per sample tick, minus one
      logic [15:0]          div;      // tick divider
      logic [2:0]           phase;    // sample phase in bit
      tsdp_pkg::tsdp_state_t state;   // radio state
      logic                 sclk;     // serial clock level
      logic                 tx_samp;  // sampled tx level
      logic                 samp_v;   // sample strobe
      logic                 rx_bit;   // rx data output level
      logic [31:0]          rdata;    // read data
   } tsdp_top_t;
   tsdp_top_t st;
   tsdp_top_t next_st;
   logic [2:0] pin_s;   // synchronised pins
   logic       wr_en;   // apb write accepted
   logic       rd_en;   // apb read accepted
   logic       tick;    // oversample tick
   logic       async_ok;
   logic       sync_ok;
   tsdp_if     bif ();
   // modulation allowed for transparent mode
   function automatic logic mod_allowed(input logic [2:0] m);
      return (m == tsdp_pkg::mod_fsk) || (m == tsdp_pkg::mod_gfsk) ||
             (m == tsdp_pkg::mod_ook);
   endfunction
   // drive a pin according to its function code
   function automatic logic pin_level(input logic [5:0] sel,
                                      input logic rxd, input logic clk,
                                      input logic zen_n);
      case (sel)
         tsdp_pkg::sel_data_out: pin_level = rxd;
         tsdp_pkg::sel_sclk:     pin_level = clk;
         tsdp_pkg::sel_zen_n:    pin_level = zen_n;
         default:                pin_level = 1'b0;
      endcase
   endfunction
   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   tsdp_sync #(.width(3)) u_sync ( // RULE_15
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .async_in (gpin_in),
      .sync_out (pin_s)
   );
   // ------------------------------------------------------------
   // receive bit buffer
   // ------------------------------------------------------------
   tsdp_buf u_buf (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .s        (bif.buf_side)
   );
   // demodulated bit offered once per bit period
   assign bif.in_valid  = rx_active && tick && (st.phase == 3'h7);
   assign bif.in_data   = demod_bit;
   // pop as the serial clock falls, so data is set up before the rise
   assign bif.out_ready = tick && (st.phase == 3'h7);
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   assign wr_en = psel & penable & pwrite & clk_en;
   assign rd_en = psel & ~penable & ~pwrite;
   assign tick  = clk_en && (st.div == 16'h0000);
   assign async_ok = (st.fmt == tsdp_pkg::fmt_async) &&
                     mod_allowed(st.modf); // RULE_01 RULE_03
   assign sync_ok  = (st.fmt == tsdp_pkg::fmt_sync) &&
                     !st.line; // RULE_07 RULE_08
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = st.rdata;
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.samp_v = 1'b0; // one-cycle pulse, held while frozen
         // register writes and strobes
         if (wr_en) begin
            case (paddr)
               tsdp_pkg::ctrl_addr: begin
                  next_st.fmt   = pwdata[tsdp_pkg::fmt_lsb +: 2];
                  next_st.line  = pwdata[tsdp_pkg::line_bit];
                  next_st.syncm = pwdata[tsdp_pkg::sync_lsb +: 3];
                  next_st.modf  = pwdata[tsdp_pkg::mod_lsb +: 3];
                  if (pwdata[tsdp_pkg::idle_bit]) // RULE_04
                     next_st.state = tsdp_pkg::tsdp_idle;
                  else if (pwdata[tsdp_pkg::tx_bit])
                     next_st.state = tsdp_pkg::tsdp_tx;
                  else if (pwdata[tsdp_pkg::rx_bit])
                     next_st.state = tsdp_pkg::tsdp_rx;
               end
               tsdp_pkg::pincfg_addr: begin
                  next_st.pin0_sel = pwdata[5:0];
                  next_st.pin1_sel = pwdata[tsdp_pkg::pin1_lsb +: 6];
                  next_st.pin2_sel = pwdata[tsdp_pkg::pin2_lsb +: 6];
               end
               tsdp_pkg::rate_addr: next_st.rate = pwdata[15:0];
               default: ;
            endcase
         end
         // read data latched in setup cycle
         if (rd_en) begin
            case (paddr)
               tsdp_pkg::ctrl_addr:
                  next_st.rdata = {21'h0, st.modf, 1'b0, st.syncm,
                                   1'b0, st.line, st.fmt};
               tsdp_pkg::pincfg_addr:
                  next_st.rdata = {10'h0, st.pin2_sel, 2'h0, st.pin1_sel,
                                   2'h0, st.pin0_sel};
               tsdp_pkg::rate_addr: next_st.rdata = {16'h0, st.rate};
               tsdp_pkg::stat_addr:
                  next_st.rdata = {26'h0, bif.out_valid, st.sclk,
                                   sync_ok, async_ok, st.state};
               default: next_st.rdata = 32'h0;
            endcase
         end
         // oversample divider, eight ticks per bit
         if (st.state == tsdp_pkg::tsdp_idle) begin
            next_st.div   = st.rate;
            next_st.phase = 3'h0;
            next_st.sclk  = 1'b0;
         end else if (tick) begin
            next_st.div   = st.rate;
            next_st.phase = st.phase + 3'h1;
            // serial clock: rises mid bit, controller samples/sets
            if (st.phase == 3'h3) next_st.sclk = 1'b1; // RULE_09
            if (st.phase == 3'h7) next_st.sclk = 1'b0;
            // transmit level sampled every tick in async mode
            if (tx_active && async_ok) begin // RULE_05
               next_st.tx_samp = pin_s[0]; // RULE_10
               next_st.samp_v  = 1'b1;
            end else if (tx_active && sync_ok && st.phase == 3'h3) begin
               next_st.tx_samp = pin_s[0];
               next_st.samp_v  = 1'b1;
            end
            // receive level out
            if (rx_active && async_ok) next_st.rx_bit = demod_bit;
            else if (bif.out_ready && bif.out_valid)
               next_st.rx_bit = bif.out_data; // RULE_11
         end else begin
            next_st.div = st.div - 16'h0001;
         end
      end
   end
   // ------------------------------------------------------------
   // register the state
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st          <= '0;
         st.pin0_sel <= tsdp_pkg::pin_reset;
         st.pin1_sel <= tsdp_pkg::pin_reset;
         st.pin2_sel <= tsdp_pkg::pin_reset;
         st.rate     <= tsdp_pkg::rate_reset;
      end else begin
         st <= next_st;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign tx_active = (st.state == tsdp_pkg::tsdp_tx) &&
                      (async_ok || sync_ok);
   assign rx_active = (st.state == tsdp_pkg::tsdp_rx) &&
                      (async_ok || sync_ok);
   assign mod_bit       = st.tx_samp;
   assign mod_bit_valid = st.samp_v;
   // async drops packet engine; sync keeps it only with framing on
   assign packet_bypass = async_ok ||
                          (sync_ok && st.syncm == 3'h0); // RULE_02 RULE_12
   assign frame_insert  = sync_ok && (st.syncm != 3'h0); // RULE_13
   // pin drivers
   always_comb begin
      gpin_out[0] = pin_level(st.pin0_sel, st.rx_bit, st.sclk,
                              ~tx_active); // RULE_14
      gpin_out[1] = pin_level(st.pin1_sel, st.rx_bit, st.sclk, ~tx_active);
      gpin_out[2] = pin_level(st.pin2_sel, st.rx_bit, st.sclk, ~tx_active);
      gpin_oe[0]  = !tx_active && (st.pin0_sel != tsdp_pkg::sel_hiz); // RULE_10
      gpin_oe[1]  = (st.pin1_sel != tsdp_pkg::sel_hiz);
      gpin_oe[2]  = (st.pin2_sel != tsdp_pkg::sel_hiz);
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_pin0_input: assert property (@(posedge core_clk) disable iff (!rstn)
      tx_active |-> !gpin_oe[0]) else $error("pin zero driven in tx"); // RULE_10
   a_async_fmt: assert property (@(posedge core_clk) disable iff (!rstn)
      async_ok |-> st.fmt == 2'h3) else $error("async wrong format"); // RULE_01
   a_sync_fmt: assert property (@(posedge core_clk) disable iff (!rstn)
      sync_ok |-> (st.fmt == 2'h1 && !st.line))
      else $error("sync wrong format"); // RULE_07
   a_async_bypass: assert property (@(posedge core_clk) disable iff (!rstn)
      async_ok |-> packet_bypass && !frame_insert)
      else $error("async not bypassed"); // RULE_02
   a_mod_legal: assert property (@(posedge core_clk) disable iff (!rstn)
      async_ok |-> st.modf inside {3'h0, 3'h1, 3'h3})
      else $error("bad modulation"); // RULE_03
   a_samp_tick: assert property (@(posedge core_clk) disable iff (!rstn)
      (tick && tx_active && async_ok && clk_en) |=> mod_bit_valid)
      else $error("sample missed"); // RULE_05
   a_zen_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      (st.pin2_sel == 6'h2d) |-> gpin_out[2] == !tx_active)
      else $error("tristate flag wrong"); // RULE_14
   a_frame_ins: assert property (@(posedge core_clk) disable iff (!rstn)
      (sync_ok && st.syncm != 3'h0) |-> frame_insert)
      else $error("framing off"); // RULE_13
   c_async_tx: cover property (@(posedge core_clk) tx_active && async_ok);
   c_sync_rx:  cover property (@(posedge core_clk) rx_active && sync_ok);
   c_sclk:     cover property (@(posedge core_clk) $rose(st.sclk));
endmodule // tsdp_port

// ===== core/tsdp_pkg.sv
package tsdp_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ctrl_addr   = 12'h000; // mode, coding, strobes
   localparam logic [11:0] pincfg_addr = 12'h004; // pin function selects
   localparam logic [11:0] rate_addr   = 12'h008; // oversample divider
   localparam logic [11:0] stat_addr   = 12'h00c; // state readback
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int fmt_lsb    = 0;  // packet_format_select [1:0]
   localparam int line_bit   = 2;  // line_code_enable
   localparam int sync_lsb   = 4;  // sync_word_mode [2:0]
   localparam int mod_lsb    = 8;  // modulation format [2:0]
   localparam int tx_bit     = 16; // transmit_strobe (write 1)
   localparam int rx_bit     = 17; // receive_strobe
   localparam int idle_bit   = 18; // idle_strobe
   localparam int pin1_lsb   = 8;  // pin_one_function_select
   localparam int pin2_lsb   = 16; // pin_two_function_select
   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] fmt_fifo  = 2'h0;
   localparam logic [1:0] fmt_sync  = 2'h1;
   localparam logic [1:0] fmt_async = 2'h3;
   localparam logic [2:0] mod_fsk   = 3'h0;
   localparam logic [2:0] mod_gfsk  = 3'h1;
   localparam logic [2:0] mod_ook   = 3'h3;
   localparam logic [5:0] sel_data_out = 6'h16; // serial rx data output
   localparam logic [5:0] sel_sclk     = 6'h0b; // serial clock output
   localparam logic [5:0] sel_zen_n    = 6'h2d; // pin-zero input flag
   localparam logic [5:0] sel_hiz      = 6'h2e; // high impedance
   localparam logic [5:0] pin_reset    = 6'h2e;
   localparam logic [15:0] rate_reset  = 16'h0004;
   localparam int          oversample  = 8;
   // ------------------------------------------------------------
   // radio states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      tsdp_idle = 2'b00,
      tsdp_rx   = 2'b01,
      tsdp_tx   = 2'b11
   } tsdp_state_t;
endpackage

// ===== core/tsdp_if.sv
`timescale 1ns/1ps
// bits between the top and the two-entry buffer
interface tsdp_if;
   logic in_valid;  // bit offered
   logic in_ready;  // buffer has room
   logic in_data;   // bit offered
   logic out_valid; // buffer holds a bit
   logic out_ready; // consumer takes it
   logic out_data;  // oldest bit
   modport buf_side (input in_valid, in_data, out_ready,
                     output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data);
endinterface

// ===== core/tsdp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bus of pins
module tsdp_sync #(
   parameter int width = 2
) (
   // clocking
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   // data
   input  wire logic [width-1:0] async_in,
   output logic      [width-1:0] sync_out
);
   typedef struct packed {
      logic [width-1:0] meta; // first stage, read by second only
      logic [width-1:0] hold; // second stage
   } tsdp_sync_t;
   tsdp_sync_t st;
   tsdp_sync_t next_st;
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.meta = async_in;
         next_st.hold = st.meta;
      end
   end
   // registered copy
   always_ff @(posedge core_clk) begin
      if (!rstn) st <= '0;
      else st <= next_st;
   end
   assign sync_out = st.hold;
endmodule // tsdp_sync

// ===== core/tsdp_buf.sv
`timescale 1ns/1ps
// two-entry buffer on the receive bit path
module tsdp_buf (
   // clocking
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic clk_en,
   // stream
   tsdp_if.buf_side  s
);
   typedef struct packed {
      logic [1:0] mem;  // entries
      logic       rd;   // read index
      logic       wr;   // write index
      logic [1:0] cnt;  // fill level
   } tsdp_buf_t;
   tsdp_buf_t st;
   tsdp_buf_t next_st;
   logic push;
   logic pop;
   assign s.in_ready  = (st.cnt != 2'h2);
   assign s.out_valid = (st.cnt != 2'h0);
   assign s.out_data  = st.mem[st.rd];
   assign push = s.in_valid & s.in_ready & clk_en;
   assign pop  = s.out_valid & s.out_ready & clk_en;
   // ------------------------------------------------------------
   // pointer and count update
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = s.in_data;
         next_st.wr = ~st.wr;
      end
      if (pop) next_st.rd = ~st.rd;
      case ({push, pop})
         2'b10:   next_st.cnt = st.cnt + 2'h1;
         2'b01:   next_st.cnt = st.cnt - 2'h1;
         default: next_st.cnt = st.cnt;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!rstn) st <= '0;
      else st <= next_st;
   end
   a_buf_no_over: assert property (@(posedge core_clk) disable iff (!rstn)
      st.cnt <= 2'h2) else $error("buffer overfilled");
endmodule // tsdp_buf

// ===== bench/tsdp_host.sv
`timescale 1ns/1ps
// controller model on the far side of the serial pins
module tsdp_host (
   // pins seen from the controller
   input  wire logic       sclk,
   input  wire logic       rxd,
   // settings from the bench
   input  wire logic       sync_en,
   input  wire logic       level,
   input  wire logic [7:0] pattern,
   // controller outputs
   output logic            txd,
   output logic [7:0]      rx_shift
);
   logic [2:0] bit_idx = 3'h0; // next pattern bit
   // ------------------------------------------------------------
   // transmit side
   // ------------------------------------------------------------
   // steady level in async mode, so no bit-period error at all
   assign txd = sync_en ? pattern[bit_idx] : level;
   // new bit set up after each falling serial clock edge
   always @(negedge sclk) begin
      if (sync_en) begin
         bit_idx <= bit_idx + 3'h1;
      end
   end
   // ------------------------------------------------------------
   // receive side
   // ------------------------------------------------------------
   initial rx_shift = 8'h00;
   // bit taken on each rising serial clock edge
   always @(posedge sclk) begin
      rx_shift <= {rx_shift[6:0], rxd};
   end
endmodule // tsdp_host

// ===== bench/tsdp_port_tb_top.sv
`timescale 1ns/1ps
module tsdp_port_tb_top;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        core_clk  = 1'b0;    // 40 MHz
   logic        rstn      = 1'b0;    // sync, active low
   logic        psel      = 1'b0;    // apb request
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  gpin_out;
   logic [2:0]  gpin_oe;
   logic [2:0]  pin;                 // resolved pin levels
   logic        demod_bit = 1'b0;    // demodulated level
   logic        mod_bit;
   logic        mod_bit_valid;
   logic        tx_active;
   logic        rx_active;
   logic        packet_bypass;
   logic        frame_insert;
   logic        host_sync = 1'b0;    // host follows serial clock
   logic        host_lvl  = 1'b0;    // host async level
   logic        host_txd;
   logic [7:0]  host_rx;
   logic [31:0] rdv;                 // last read word
   logic [2:0]  mv;
   logic        ok;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          cyc        = 0;
   int          n;
   int          c;
   localparam logic [2:0] s_tx   = 3'h1; // strobe bits
   localparam logic [2:0] s_rx   = 3'h2;
   localparam logic [2:0] s_idle = 3'h4;
   // ------------------------------------------------------------
   // pins: host drives pin zero when released, others follow output when enabled, inverse when not
   // ------------------------------------------------------------
   assign pin[0]   = gpin_oe[0] ? gpin_out[0] : host_txd;
   assign pin[2:1] = ~(gpin_oe[2:1] ^ gpin_out[2:1]);
   tsdp_port dut (
      .core_clk(core_clk), .rstn(rstn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .gpin_in(pin), .gpin_out(gpin_out), .gpin_oe(gpin_oe),
      .demod_bit(demod_bit), .mod_bit(mod_bit),
      .mod_bit_valid(mod_bit_valid), .tx_active(tx_active),
      .rx_active(rx_active), .packet_bypass(packet_bypass),
      .frame_insert(frame_insert));
   tsdp_host host (
      .sclk(pin[1]), .rxd(pin[2]), .sync_en(host_sync),
      .level(host_lvl), .pattern(8'hb4), .txd(host_txd),
      .rx_shift(host_rx));
   always #12.5 core_clk = ~core_clk;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer, setup then access until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) fail_count++;
      rdv = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic nwait(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   // cycles until the serial clock pin next rises
   task automatic sclk_rise(output int k);
      k = 0;
      while (pin[1] !== 1'b0 && k < 200) begin
         @(negedge core_clk);
         k++;
      end
      while (pin[1] !== 1'b1 && k < 200) begin
         @(negedge core_clk);
         k++;
      end
   endtask
   function automatic logic [31:0] cw(logic [1:0] f, logic ln,
                                      logic [2:0] sm, md, stb);
      cw = {13'h0000, stb, 5'h00, md, 1'b0, sm, 1'b0, ln, f};
   endfunction
   function automatic logic [31:0] pc(logic [5:0] p0, p1, p2);
      pc = {10'h000, p2, 2'h0, p1, 2'h0, p0};
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      // reset values, unmapped word
      apb(1'b0, tsdp_pkg::pincfg_addr, 32'h0);
      chk(rdv, 32'h002e2e2e);
      apb(1'b0, tsdp_pkg::rate_addr, 32'h0);
      chk(rdv, 32'h00000004);
      apb(1'b1, 12'h010, 32'hffffffff);
      apb(1'b0, 12'h010, 32'h0);
      chk(rdv, 32'h0);
      chk(pslverr, 1'b0);
      apb(1'b0, tsdp_pkg::stat_addr, 32'h0);
      chk(rdv & 32'h33, 32'h0);
      chk({29'h0, gpin_oe}, 32'h0);
      $display("test reset done");
      // every modulation code in async mode
      for (int m = 0; m < 8; m++) begin
         mv = 3'(m);
         ok = (mv == tsdp_pkg::mod_fsk) || (mv == tsdp_pkg::mod_gfsk)
              || (mv == tsdp_pkg::mod_ook);
         apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h3, 1'b0, 3'h0, mv, s_tx));
         nwait(4);
         chk(tx_active, ok);
         chk(packet_bypass, ok);
         apb(1'b0, tsdp_pkg::stat_addr, 32'h0);
         chk(rdv[2], ok);
         apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h3, 1'b0, 3'h0, mv, s_idle));
      end
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h0, 1'b0, 3'h0, 3'h0, 3'h0));
      nwait(2);
      chk(packet_bypass, 1'b0);
      $display("test modulation done");
      // async transmit, idle beats transmit strobe
      apb(1'b1, tsdp_pkg::pincfg_addr, pc(tsdp_pkg::sel_data_out,
          tsdp_pkg::sel_hiz, tsdp_pkg::sel_zen_n));
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h3, 1'b0, 3'h0, 3'h1, 3'h5));
      nwait(4);
      chk(tx_active, 1'b0);
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h3, 1'b0, 3'h0, 3'h1, s_tx));
      host_lvl <= 1'b1;
      nwait(60);
      chk(gpin_oe[0], 1'b0);
      chk({gpin_oe[2], gpin_out[2]}, 2'b10);
      chk(mod_bit, 1'b1);
      @(posedge core_clk);
      host_lvl <= 1'b0;
      nwait(60);
      chk(mod_bit, 1'b0);
      for (int r = 0; r < 5; r += 4) begin
         apb(1'b1, tsdp_pkg::rate_addr, 32'(r));
         nwait(20);
         c = 0;
         repeat (10 * tsdp_pkg::oversample * (r + 1)) begin
            @(negedge core_clk);
            if (mod_bit_valid === 1'b1) c++;
         end
         chk(c, 32'd80);
      end
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h3, 1'b0, 3'h0, 3'h1, s_idle));
      nwait(4);
      chk({gpin_oe[2], gpin_out[2]}, 2'b11);
      chk(tx_active, 1'b0);
      $display("test async transmit done");
      // async receive on each pin in turn
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h3, 1'b0, 3'h0, 3'h3, s_rx));
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, tsdp_pkg::pincfg_addr, pc(
             k == 0 ? tsdp_pkg::sel_data_out : tsdp_pkg::sel_hiz,
             k == 1 ? tsdp_pkg::sel_data_out : tsdp_pkg::sel_hiz,
             k == 2 ? tsdp_pkg::sel_data_out : tsdp_pkg::sel_hiz));
         for (int v = 1; v >= 0; v--) begin
            @(posedge core_clk);
            demod_bit <= 1'(v);
            nwait(50);
            chk({gpin_oe[k], gpin_out[k]}, {1'b1, 1'(v)});
            chk(rx_active, 1'b1);
         end
      end
      $display("test async receive done");
      // synchronous mode, framed transmit
      apb(1'b1, tsdp_pkg::pincfg_addr, pc(tsdp_pkg::sel_hiz,
          tsdp_pkg::sel_sclk, tsdp_pkg::sel_data_out));
      host_sync <= 1'b1;
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h1, 1'b0, 3'h2, 3'h0, s_tx));
      nwait(4);
      chk(frame_insert, 1'b1);
      chk(tx_active, 1'b1);
      sclk_rise(n);
      sclk_rise(n);
      chk(n, 32'(tsdp_pkg::oversample * 5));
      for (int b = 0; b < 8; b++) begin
         sclk_rise(n);
         nwait(2);
         chk({gpin_oe[0], mod_bit}, {1'b0, host_txd});
      end
      // unframed receive, controller handles framing
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h1, 1'b0, 3'h0, 3'h0, s_rx));
      demod_bit <= 1'b1;
      nwait(4);
      chk(frame_insert, 1'b0);
      chk(rx_active, 1'b1);
      repeat (4) sclk_rise(n);
      chk(host_rx[1:0], 2'b11);
      // line coding on makes synchronous mode illegal
      apb(1'b1, tsdp_pkg::ctrl_addr, cw(2'h1, 1'b1, 3'h0, 3'h0, s_tx));
      nwait(4);
      chk(tx_active, 1'b0);
      apb(1'b0, tsdp_pkg::stat_addr, 32'h0);
      chk(rdv[3], 1'b0);
      $display("test sync mode done");
      tally_and_finish();
   end
endmodule // tsdp_port_tb_top
